//--- ept_pkg.sv
/*
  Constants, types and helpers for the exception preemption and
  tail-chain sequencer. Assumes group priorities are small signed
  numbers where a lower value is more urgent.
*/
package ept_pkg;

  localparam int EPT_NW = 6;
  localparam int EPT_PW = 4;
  localparam logic [3:0] EPT_PRI_NMI = 4'hE;
  localparam logic [3:0] EPT_PRI_HF = 4'hF;
  localparam logic [3:0] EPT_PRI_BOOST = 4'h0;
  localparam logic [3:0] EPT_PRI_THREAD = 4'h4;
  localparam logic [5:0] EPT_NUM_HF = 6'h03;
  localparam logic [3:0] EPT_LINK_PREFIX = 4'hF;
  localparam logic [3:0] EPT_RC_HND_MAIN = 4'h1;
  localparam logic [3:0] EPT_RC_THR_MAIN = 4'h9;
  localparam logic [3:0] EPT_RC_THR_PROC = 4'hD;
  localparam logic [3:0] EPT_REG_CTRL = 4'h0;
  localparam logic [3:0] EPT_REG_STAT = 4'h4;
  localparam int EPT_CB_LATE = 0;
  localparam int EPT_CB_TC = 1;
  localparam int EPT_CB_IRQRET = 2;
  localparam int EPT_CB_LIM_LO = 4;
  localparam logic [7:0] EPT_CTRL_RST = 8'h87;

  typedef struct packed {
    logic [EPT_NW-1:0] num;
    logic [EPT_PW-1:0] pri;
  } ept_exc_type;

  typedef enum logic [1:0] {
    EPT_IDLE = 2'b00,
    EPT_ENTRY = 2'b01,
    EPT_RET = 2'b10,
    EPT_LOCK = 2'b11
  } ept_state_type;

  typedef enum logic [1:0] {
    EPT_D_HND_MAIN = 2'b00,
    EPT_D_THR_MAIN = 2'b01,
    EPT_D_THR_PROC = 2'b10,
    EPT_D_BAD = 2'b11
  } ept_dest_type;

  // Signed compare: a strictly more urgent than b
  function automatic logic ept_urgent(input logic [3:0] a, input logic [3:0] b);
    ept_urgent = $signed(a) < $signed(b);
  endfunction

endpackage

//--- ept_seq.sv
/*
  Exception sequencer: late arrival, derived faults on entry and
  return, tail-chaining and load-multiple PC restore. Assumes all
  inputs come from pipeline and bus logic on mclk_in.
*/
`timescale 1ns/1ns
`default_nettype none
module ept_seq
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Entry request
  input wire logic entry_start_in,
  input wire ept_pkg::ept_exc_type entry_exc_in,
  input wire logic [3:0] preempt_pri_in,
  input wire logic lmul_pc_early_in,
  input wire logic [31:0] lmul_addr_in,
  input wire logic late_valid_in,
  input wire ept_pkg::ept_exc_type late_exc_in,
  input wire logic stack_wr_err_in,
  input wire logic vec_rd_err_in,
  input wire logic entry_done_in,
  // Return request
  input wire logic ret_start_in,
  input wire logic [27:0] ret_code_in,
  input wire ept_pkg::ept_exc_type ret_exc_in,
  input wire logic handler_mode_in,
  input wire logic [3:0] act_top_pri_in,
  input wire logic boost_mask_in,
  input wire logic pend_valid_in,
  input wire ept_pkg::ept_exc_type pend_exc_in,
  input wire logic restore_beat_in,
  input wire logic restore_err_in,
  input wire logic restore_done_in,
  // Results
  output logic take_out,
  output logic [5:0] take_num_out,
  output logic pend_out,
  output logic [5:0] pend_num_out,
  output logic hf_pend_out,
  output logic deact_out,
  output logic [5:0] deact_num_out,
  output logic link_wr_out,
  output logic [31:0] link_value_out,
  output logic skip_unstack_out,
  output logic pc_restore_out,
  output logic [31:0] pc_addr_out,
  output logic [3:0] target_pri_out,
  output logic [1:0] ret_dest_out,
  output logic ret_end_out,
  output logic lockup_out
);

  ept_pkg::ept_state_type state_ff, nxt_state;
  ept_pkg::ept_exc_type cur_ff, nxt_cur;
  logic [3:0] pre_pri_ff, nxt_pre_pri;
  logic [27:0] rcode_ff, nxt_rcode;
  ept_pkg::ept_exc_type rexc_ff, nxt_rexc;
  logic tcok_ff, nxt_tcok;
  logic [3:0] beats_ff, nxt_beats;
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [5:0] last_ff, nxt_last;
  logic take_ff, nxt_take;
  logic [5:0] take_num_ff, nxt_take_num;
  logic pend_ff, nxt_pend;
  logic [5:0] pend_num_ff, nxt_pend_num;
  logic hfp_ff, nxt_hfp;
  logic deact_ff, nxt_deact;
  logic [5:0] deact_num_ff, nxt_deact_num;
  logic link_wr_ff, nxt_link_wr;
  logic [31:0] link_ff, nxt_link;
  logic skip_ff, nxt_skip;
  logic pcr_ff, nxt_pcr;
  logic [31:0] pca_ff, nxt_pca;
  logic [3:0] tgt_ff, nxt_tgt;
  logic [1:0] dest_ff, nxt_dest;
  logic rend_ff, nxt_rend;
  logic lock_ff, nxt_lock;

  logic late_en;
  logic tc_en;
  logic irq_ret_en;
  logic [3:0] beat_lim;
  logic entry_err;
  logic late_win;
  logic [3:0] tgt_now;
  logic tc_room;
  ept_pkg::ept_exc_type hf_exc;

  assign late_en = ctrl_ff[ept_pkg::EPT_CB_LATE];
  assign tc_en = ctrl_ff[ept_pkg::EPT_CB_TC];
  assign irq_ret_en = ctrl_ff[ept_pkg::EPT_CB_IRQRET];
  assign beat_lim = ctrl_ff[ept_pkg::EPT_CB_LIM_LO +: 4];
  assign hf_exc = '{num: ept_pkg::EPT_NUM_HF, pri: ept_pkg::EPT_PRI_HF};
  assign entry_err = stack_wr_err_in | vec_rd_err_in;
  // Any kind of late candidate qualifies; only its priority matters
  assign late_win = late_en & late_valid_in
    & ept_pkg::ept_urgent(late_exc_in.pri, cur_ff.pri);
  // Boost raises execution priority to the boost level
  assign tgt_now = ept_pkg::ept_urgent(act_top_pri_in,
    boost_mask_in ? ept_pkg::EPT_PRI_BOOST : ept_pkg::EPT_PRI_THREAD)
    ? act_top_pri_in
    : (boost_mask_in ? ept_pkg::EPT_PRI_BOOST : ept_pkg::EPT_PRI_THREAD);
  assign tc_room = tc_en & tcok_ff & (beats_ff < beat_lim);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cur = cur_ff;
    nxt_pre_pri = pre_pri_ff;
    nxt_rcode = rcode_ff;
    nxt_rexc = rexc_ff;
    nxt_tcok = tcok_ff;
    nxt_beats = beats_ff;
    nxt_ctrl = ctrl_ff;
    nxt_rdata = 32'h0000_0000;
    nxt_last = last_ff;
    nxt_take = 1'b0;
    nxt_take_num = take_num_ff;
    nxt_pend = 1'b0;
    nxt_pend_num = pend_num_ff;
    nxt_hfp = 1'b0;
    nxt_deact = 1'b0;
    nxt_deact_num = deact_num_ff;
    nxt_link_wr = 1'b0;
    nxt_link = link_ff;
    nxt_skip = 1'b0;
    nxt_pcr = 1'b0;
    nxt_pca = pca_ff;
    nxt_tgt = tgt_ff;
    nxt_dest = dest_ff;
    nxt_rend = 1'b0;
    nxt_lock = lock_ff;
    if (reg_wr_in && reg_addr_in == ept_pkg::EPT_REG_CTRL)
    begin
      nxt_ctrl = reg_wdata_in[7:0];
    end
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        ept_pkg::EPT_REG_CTRL: nxt_rdata = {24'h00_0000, ctrl_ff};
        ept_pkg::EPT_REG_STAT: nxt_rdata = {19'h0_0000, lock_ff, last_ff, state_ff, tgt_ff};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
    case (state_ff)
      ept_pkg::EPT_IDLE:
      begin
        if (entry_start_in)
        begin
          nxt_state = ept_pkg::EPT_ENTRY;
          nxt_cur = entry_exc_in;
          nxt_pre_pri = preempt_pri_in;
          // Return address must point back at the load-multiple
          if (lmul_pc_early_in)
          begin
            nxt_pcr = 1'b1;
            nxt_pca = lmul_addr_in;
          end
        end
        else if (ret_start_in)
        begin
          nxt_state = ept_pkg::EPT_RET;
          nxt_rcode = ret_code_in;
          nxt_rexc = ret_exc_in;
          nxt_tcok = handler_mode_in & (&ret_code_in[27:4]);
          nxt_beats = 4'h0;
          case (ret_code_in[3:0])
            ept_pkg::EPT_RC_HND_MAIN: nxt_dest = ept_pkg::EPT_D_HND_MAIN;
            ept_pkg::EPT_RC_THR_MAIN: nxt_dest = ept_pkg::EPT_D_THR_MAIN;
            ept_pkg::EPT_RC_THR_PROC: nxt_dest = ept_pkg::EPT_D_THR_PROC;
            default: nxt_dest = ept_pkg::EPT_D_BAD;
          endcase
        end
      end
      ept_pkg::EPT_ENTRY:
      begin
        if (entry_err)
        begin
          if (pre_pri_ff == ept_pkg::EPT_PRI_HF)
          begin
            nxt_lock = 1'b1;
            nxt_state = ept_pkg::EPT_LOCK;
          end
          else if (cur_ff.pri == ept_pkg::EPT_PRI_NMI)
          begin
            nxt_hfp = 1'b1;
          end
          else
          begin
            nxt_hfp = 1'b1;
            if (late_en)
            begin
              nxt_pend = 1'b1;
              nxt_pend_num = cur_ff.num;
              nxt_cur = hf_exc;
            end
          end
        end
        else if (late_win)
        begin
          // Stacking carries on; only the vector changes
          nxt_pend = 1'b1;
          nxt_pend_num = cur_ff.num;
          nxt_cur = late_exc_in;
        end
        else if (entry_done_in)
        begin
          nxt_take = 1'b1;
          nxt_take_num = cur_ff.num;
          nxt_last = cur_ff.num;
          nxt_state = ept_pkg::EPT_IDLE;
        end
      end
      ept_pkg::EPT_RET:
      begin
        nxt_tgt = tgt_now;
        if (restore_beat_in)
        begin
          nxt_beats = beats_ff + 4'h1;
        end
        if (restore_err_in)
        begin
          // Restored state is untrusted
          if (!ept_pkg::ept_urgent(ept_pkg::EPT_PRI_HF, rexc_ff.pri))
          begin
            nxt_lock = 1'b1;
            nxt_state = ept_pkg::EPT_LOCK;
          end
          else if (tc_en & tcok_ff)
          begin
            nxt_link_wr = 1'b1;
            nxt_link = {ept_pkg::EPT_LINK_PREFIX, rcode_ff};
            nxt_deact = 1'b1;
            nxt_deact_num = rexc_ff.num;
            nxt_skip = 1'b1;
            nxt_cur = hf_exc;
            nxt_pre_pri = tgt_now;
            nxt_state = ept_pkg::EPT_ENTRY;
          end
          else
          begin
            nxt_hfp = 1'b1;
            nxt_rend = 1'b1;
            nxt_state = ept_pkg::EPT_IDLE;
          end
        end
        else if (irq_ret_en && tc_room && pend_valid_in
          && ept_pkg::ept_urgent(pend_exc_in.pri, tgt_now))
        begin
          // Deactivate touches only the active flag
          nxt_link_wr = 1'b1;
          nxt_link = {ept_pkg::EPT_LINK_PREFIX, rcode_ff};
          nxt_deact = 1'b1;
          nxt_deact_num = rexc_ff.num;
          nxt_skip = 1'b1;
          nxt_cur = pend_exc_in;
          nxt_pre_pri = tgt_now;
          nxt_state = ept_pkg::EPT_ENTRY;
        end
        else if (restore_done_in)
        begin
          nxt_deact = 1'b1;
          nxt_deact_num = rexc_ff.num;
          nxt_rend = 1'b1;
          nxt_state = ept_pkg::EPT_IDLE;
        end
      end
      ept_pkg::EPT_LOCK:
      begin
        nxt_state = ept_pkg::EPT_LOCK;
      end
      default:
      begin
        nxt_state = ept_pkg::EPT_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      state_ff <= ept_pkg::EPT_IDLE;
      cur_ff <= '0;
      pre_pri_ff <= ept_pkg::EPT_PRI_THREAD;
      rcode_ff <= 28'h000_0000;
      rexc_ff <= '0;
      tcok_ff <= 1'b0;
      beats_ff <= 4'h0;
      ctrl_ff <= ept_pkg::EPT_CTRL_RST;
      rdata_ff <= 32'h0000_0000;
      last_ff <= 6'h00;
      take_ff <= 1'b0;
      take_num_ff <= 6'h00;
      pend_ff <= 1'b0;
      pend_num_ff <= 6'h00;
      hfp_ff <= 1'b0;
      deact_ff <= 1'b0;
      deact_num_ff <= 6'h00;
      link_wr_ff <= 1'b0;
      link_ff <= 32'h0000_0000;
      skip_ff <= 1'b0;
      pcr_ff <= 1'b0;
      pca_ff <= 32'h0000_0000;
      tgt_ff <= ept_pkg::EPT_PRI_THREAD;
      dest_ff <= 2'h0;
      rend_ff <= 1'b0;
      lock_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cur_ff <= nxt_cur;
      pre_pri_ff <= nxt_pre_pri;
      rcode_ff <= nxt_rcode;
      rexc_ff <= nxt_rexc;
      tcok_ff <= nxt_tcok;
      beats_ff <= nxt_beats;
      ctrl_ff <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
      last_ff <= nxt_last;
      take_ff <= nxt_take;
      take_num_ff <= nxt_take_num;
      pend_ff <= nxt_pend;
      pend_num_ff <= nxt_pend_num;
      hfp_ff <= nxt_hfp;
      deact_ff <= nxt_deact;
      deact_num_ff <= nxt_deact_num;
      link_wr_ff <= nxt_link_wr;
      link_ff <= nxt_link;
      skip_ff <= nxt_skip;
      pcr_ff <= nxt_pcr;
      pca_ff <= nxt_pca;
      tgt_ff <= nxt_tgt;
      dest_ff <= nxt_dest;
      rend_ff <= nxt_rend;
      lock_ff <= nxt_lock;
    end
  end

  assign reg_rdata_out = rdata_ff;
  assign take_out = take_ff;
  assign take_num_out = take_num_ff;
  assign pend_out = pend_ff;
  assign pend_num_out = pend_num_ff;
  assign hf_pend_out = hfp_ff;
  assign deact_out = deact_ff;
  assign deact_num_out = deact_num_ff;
  assign link_wr_out = link_wr_ff;
  assign link_value_out = link_ff;
  assign skip_unstack_out = skip_ff;
  assign pc_restore_out = pcr_ff;
  assign pc_addr_out = pca_ff;
  assign target_pri_out = tgt_ff;
  assign ret_dest_out = dest_ff;
  assign ret_end_out = rend_ff;
  assign lockup_out = lock_ff;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_tc_step;
    link_wr_out && deact_out && skip_unstack_out;
  endsequence

  a_lmul_pc_restore: assert property (
    state_ff == ept_pkg::EPT_IDLE && entry_start_in && lmul_pc_early_in
    |=> pc_restore_out && pc_addr_out == $past(lmul_addr_in))
    else $error("load-multiple pc not restored");
  a_late_swap: assert property (
    state_ff == ept_pkg::EPT_ENTRY && !entry_err && late_win
    |=> pend_out && pend_num_out == $past(cur_ff.num) && cur_ff == $past(late_exc_in))
    else $error("late arrival not swapped in");
  a_late_equal: assert property (
    state_ff == ept_pkg::EPT_ENTRY && !entry_err && late_valid_in
    && late_exc_in.pri == cur_ff.pri |=> !pend_out)
    else $error("equal priority preempted");
  a_entry_lockup: assert property (
    state_ff == ept_pkg::EPT_ENTRY && entry_err && pre_pri_ff == ept_pkg::EPT_PRI_HF
    |=> lockup_out && !hf_pend_out ##1 lockup_out)
    else $error("no lockup on derived fault");
  a_nmi_no_preempt: assert property (
    state_ff == ept_pkg::EPT_ENTRY && entry_err && cur_ff.pri == ept_pkg::EPT_PRI_NMI
    && pre_pri_ff != ept_pkg::EPT_PRI_HF |=> hf_pend_out && !pend_out && !take_out)
    else $error("non-maskable entry preempted");
  a_entry_take: assert property (
    state_ff == ept_pkg::EPT_ENTRY && entry_done_in && !entry_err && !late_win
    |=> take_out && take_num_out == $past(cur_ff.num))
    else $error("entry did not take current exception");
  a_tc_link_code: assert property (
    link_wr_out |-> s_tc_step and (link_value_out[31:28] == ept_pkg::EPT_LINK_PREFIX
    && state_ff == ept_pkg::EPT_ENTRY))
    else $error("tail-chain step malformed");
  a_ret_irq_off: assert property (
    state_ff == ept_pkg::EPT_RET && !irq_ret_en && !restore_err_in |=> !link_wr_out)
    else $error("tail-chain with interrupts off");
  a_tc_needs_mode: assert property (
    state_ff == ept_pkg::EPT_RET && !tcok_ff |=> !link_wr_out)
    else $error("tail-chain without handler return code");
  a_ret_target: assert property (
    state_ff == ept_pkg::EPT_RET && boost_mask_in
    |=> !ept_pkg::ept_urgent(ept_pkg::EPT_PRI_BOOST, target_pri_out))
    else $error("boost ignored in target");

endmodule
`default_nettype wire

//--- ept_bus_model.sv
/*
  Behavioural pipeline and bus partner of the exception sequencer:
  answers entry stacking with vector fetch and return with restore loads.
  Assumes single-cycle commands from the bench on mclk_in edges.
*/
`timescale 1ns/1ns
`default_nettype none
module ept_bus_model
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Commands from the bench
  input wire logic ent_go_in,
  input wire logic ret_go_in,
  input wire logic vec_err_in,
  input wire logic [3:0] beats_in,
  input wire logic [3:0] dly_in,
  // Answers towards the sequencer
  output logic entry_done_out,
  output logic vec_rd_err_out,
  output logic restore_beat_out,
  output logic restore_done_out
);
  logic [1:0] mode_ff;
  logic [3:0] cnt_ff;
  logic [3:0] left_ff;
  logic erred_ff;

  // A new entry command aborts any restore in flight, as a tail-chain does
  always @(posedge mclk_in)
  begin
    {entry_done_out, vec_rd_err_out, restore_beat_out, restore_done_out} <= 4'h0;
    if (rst_in)
    begin
      mode_ff <= 2'h0;
    end
    else if (ent_go_in)
    begin
      {mode_ff, cnt_ff, erred_ff} <= {2'h1, dly_in, 1'b0};
    end
    else if (ret_go_in)
    begin
      {mode_ff, cnt_ff, left_ff} <= {2'h2, dly_in, beats_in};
    end
    else if (mode_ff != 2'h0)
    begin
      if (cnt_ff != 4'h0)
        cnt_ff <= cnt_ff - 4'h1;
      else if (mode_ff == 2'h1 && vec_err_in && !erred_ff)
      begin
        // Faulted vector read, then the refetch for the hard fault
        {vec_rd_err_out, erred_ff, cnt_ff} <= {2'b11, dly_in};
      end
      else if (mode_ff == 2'h1)
        {entry_done_out, mode_ff} <= {1'b1, 2'h0};
      else if (left_ff != 4'h0)
        {restore_beat_out, left_ff, cnt_ff} <= {1'b1, left_ff - 4'h1, dly_in};
      else
        {restore_done_out, mode_ff} <= {1'b1, 2'h0};
    end
  end
endmodule
`default_nettype wire

//--- tb_top.sv
/*
  Self-checking bench of the exception sequencer.
  Assumes the partner model ept_bus_model answers entries and returns.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic mclk_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic entry_start_in = 1'b0, lmul_pc_early_in = 1'b0, late_valid_in = 1'b0;
  logic stack_wr_err_in = 1'b0, ret_start_in = 1'b0, boost_mask_in = 1'b0;
  logic handler_mode_in = 1'b1, pend_valid_in = 1'b0, restore_err_in = 1'b0;
  logic ent_go = 1'b0, ret_go = 1'b0, vec_err = 1'b0, clr = 1'b0;
  logic [3:0] reg_addr_in = 4'h0, preempt_pri_in = 4'h4, act_top_pri_in = 4'h4, dly = 4'h3;
  logic [27:0] ret_code_in = 28'hFFFFFF1;
  logic [31:0] reg_wdata_in = 32'h0, lmul_addr_in = 32'h0;
  ept_pkg::ept_exc_type entry_exc_in = '0, late_exc_in = '0, ret_exc_in = '0, pend_exc_in = '0;
  logic entry_done_in, vec_rd_err_in, restore_beat_in, restore_done_in;
  logic take_out, pend_out, hf_pend_out, deact_out, link_wr_out, skip_unstack_out;
  logic pc_restore_out, ret_end_out, lockup_out;
  logic [5:0] take_num_out, pend_num_out, deact_num_out, c_take, c_pend, c_deact;
  logic [31:0] reg_rdata_out, link_value_out, pc_addr_out, c_link, c_pc;
  logic [3:0] target_pri_out, c_tgt;
  logic [1:0] ret_dest_out, c_dest;
  logic s_take = 1'b0, s_pend = 1'b0, s_hf = 1'b0, s_skip = 1'b0, s_pc = 1'b0, s_end = 1'b0;
  int bad_count = 0, checks = 0;
  localparam logic [5:0] LN [4] = '{6'h11, 6'h0B, 6'h03, 6'h14};
  localparam logic [3:0] LP [4] = '{4'h1, 4'h1, 4'hF, 4'h2};
  localparam logic [3:0] T_BOOST = 4'h2, T_HM = 4'hB, T_UP = 4'h7, T_TC = 4'h1;
  localparam logic [15:0] D_NIB = 16'h59D1;
  localparam logic [7:0] D_EXP = 8'hD8;

  ept_seq u_ept_seq
  (
    .mclk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .entry_start_in, .entry_exc_in, .preempt_pri_in, .lmul_pc_early_in, .lmul_addr_in,
    .late_valid_in, .late_exc_in, .stack_wr_err_in, .vec_rd_err_in, .entry_done_in,
    .ret_start_in, .ret_code_in, .ret_exc_in, .handler_mode_in, .act_top_pri_in,
    .boost_mask_in, .pend_valid_in, .pend_exc_in, .restore_beat_in, .restore_err_in,
    .restore_done_in, .take_out, .take_num_out, .pend_out, .pend_num_out, .hf_pend_out,
    .deact_out, .deact_num_out, .link_wr_out, .link_value_out, .skip_unstack_out,
    .pc_restore_out, .pc_addr_out, .target_pri_out, .ret_dest_out, .ret_end_out, .lockup_out
  );

  ept_bus_model u_ept_bus_model
  (
    .mclk_in, .rst_in, .ent_go_in(ent_go), .ret_go_in(ret_go), .vec_err_in(vec_err),
    .beats_in(4'h2), .dly_in(dly), .entry_done_out(entry_done_in),
    .vec_rd_err_out(vec_rd_err_in), .restore_beat_out(restore_beat_in),
    .restore_done_out(restore_done_in)
  );

  always #5 mclk_in = ~mclk_in;

  // Pulses are latched so each scenario judges them after the fact
  always @(posedge mclk_in)
  begin
    if (clr)
      {s_take, s_pend, s_hf, s_skip, s_pc, s_end} <= 6'h00;
    else
      {s_take, s_pend, s_hf, s_skip, s_pc, s_end} <= {s_take, s_pend, s_hf, s_skip, s_pc,
        s_end} | {take_out, pend_out, hf_pend_out, skip_unstack_out, pc_restore_out, ret_end_out};
    if (take_out) c_take <= take_num_out;
    if (pend_out) c_pend <= pend_num_out;
    if (deact_out) {c_deact, c_tgt} <= {deact_num_out, target_pri_out};
    if (link_wr_out) c_link <= link_value_out;
    if (pc_restore_out) c_pc <= pc_addr_out;
    if (ret_end_out) c_dest <= ret_dest_out;
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic conclude;
    if (bad_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask

  task automatic do_rst;
    @(posedge mclk_in);
    rst_in <= 1'b1;
    cyc(16);
    rst_in <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, d, 1'b1};
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk_in);
    {reg_addr_in, reg_rd_in} <= {a, 1'b1};
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    @(negedge mclk_in);
    chk("reg_rdata", reg_rdata_out, e);
  endtask

  task automatic ent_start(input logic [5:0] n, input logic [3:0] p, input logic [3:0] pp);
    @(posedge mclk_in);
    clr <= 1'b1;
    @(posedge mclk_in);
    {clr, entry_start_in, ent_go, entry_exc_in, preempt_pri_in} <= {3'b011, n, p, pp};
    @(posedge mclk_in);
    {entry_start_in, ent_go} <= 2'b00;
  endtask

  task automatic ret_begin(input logic [27:0] code, input logic [5:0] n, input logic [3:0] p);
    @(posedge mclk_in);
    clr <= 1'b1;
    @(posedge mclk_in);
    {clr, ret_start_in, ret_go, ret_code_in, ret_exc_in} <= {3'b011, code, n, p};
    @(posedge mclk_in);
    {ret_start_in, ret_go} <= 2'b00;
  endtask

  // After a merge the pipeline goes on with the new entry
  task automatic tc_go;
    cyc(3);
    if (s_skip === 1'b1)
    begin
      ent_go <= 1'b1;
      @(posedge mclk_in);
      ent_go <= 1'b0;
    end
    cyc(14);
  endtask

  task automatic rerr;
    restore_err_in <= 1'b1;
    @(posedge mclk_in);
    restore_err_in <= 1'b0;
  endtask

  task automatic t_regs;
    rd(4'h0, 32'h87);
    rd(4'h4, 32'h4);
    rd(4'h8, 32'h0);
    wr(4'h4, 32'hFFFF);
    rd(4'h4, 32'h4);
    wr(4'h0, 32'h05);
    rd(4'h0, 32'h05);
    wr(4'h0, 32'h87);
  endtask

  task automatic t_late;
    for (int i = 0; i < 4; i++)
    begin
      ent_start(6'h10, 4'h2, 4'h4);
      {late_valid_in, late_exc_in} <= {1'b1, LN[i], LP[i]};
      cyc(10);
      late_valid_in <= 1'b0;
      chk("late_take", 32'(c_take), (i < 3) ? 32'(LN[i]) : 32'h10);
      chk("late_pend", 32'(s_pend ? c_pend : 6'h3F), (i < 3) ? 32'h10 : 32'h3F);
      chk("lmul_quiet", 32'(s_pc), 32'h0);
    end
  endtask

  task automatic t_lmul;
    {lmul_pc_early_in, lmul_addr_in} <= {1'b1, 32'h00001234};
    ent_start(6'h10, 4'h2, 4'h4);
    cyc(10);
    lmul_pc_early_in <= 1'b0;
    chk("pc_restore", 32'(s_pc), 32'h1);
    chk("pc_addr", c_pc, 32'h00001234);
  endtask

  task automatic t_derv;
    vec_err <= 1'b1;
    ent_start(6'h10, 4'h2, 4'h4);
    cyc(14);
    chk("derv_hf", 32'(s_hf), 32'h1);
    chk("derv_take", 32'(c_take), 32'h3);
    chk("derv_pend", 32'(c_pend), 32'h10);
    ent_start(6'h02, 4'hE, 4'h4);
    cyc(14);
    vec_err <= 1'b0;
    chk("nmi_take", 32'(c_take), 32'h2);
    chk("nmi_pend", 32'(s_pend), 32'h0);
    ent_start(6'h10, 4'h2, 4'hF);
    stack_wr_err_in <= 1'b1;
    @(posedge mclk_in);
    stack_wr_err_in <= 1'b0;
    cyc(3);
    chk("lockup", 32'(lockup_out), 32'h1);
    do_rst;
  endtask

  task automatic t_tail;
    {pend_valid_in, pend_exc_in} <= {1'b1, 6'h12, 4'h1};
    for (int i = 0; i < 4; i++)
    begin
      {boost_mask_in, handler_mode_in} <= {T_BOOST[i], T_HM[i]};
      ret_begin(T_UP[i] ? 28'hFFFFFF1 : 28'hFFFFFE1, 6'h10, 4'h2);
      tc_go;
      chk("tc_skip", 32'(s_skip), 32'(T_TC[i]));
      chk("tc_take", 32'(s_take ? c_take : 6'h3F), T_TC[i] ? 32'h12 : 32'h3F);
      chk("tc_deact", 32'(c_deact), 32'h10);
      chk("tc_target", 32'(c_tgt), T_BOOST[i] ? 32'h0 : 32'h4);
      chk("tc_end", 32'(s_end), 32'(!T_TC[i]));
    end
    chk("tc_link", c_link, 32'hFFFFFFF1);
    // Active level 1 beats thread level; pending at 1 is then not urgent enough
    act_top_pri_in <= 4'h1;
    ret_begin(28'hFFFFFF1, 6'h10, 4'h2);
    tc_go;
    chk("tc_active", 32'({c_tgt, s_skip}), 32'h2);
    act_top_pri_in <= 4'h4;
    {boost_mask_in, handler_mode_in, pend_valid_in} <= 3'b010;
  endtask

  task automatic t_dest;
    dly <= 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      ret_begin({24'hFFFFFF, D_NIB[4*i +: 4]}, 6'h10, 4'h2);
      cyc(14);
      chk("ret_dest", 32'(c_dest), 32'(D_EXP[2*i +: 2]));
    end
    dly <= 4'h3;
  endtask

  task automatic t_ctrl;
    pend_valid_in <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      wr(4'h0, (i == 0) ? 32'h83 : 32'h07);
      ret_begin(28'hFFFFFF1, 6'h10, 4'h2);
      tc_go;
      chk("ctrl_skip", 32'(s_skip), 32'h0);
      chk("ctrl_end", 32'(s_end), 32'h1);
    end
    pend_valid_in <= 1'b0;
    wr(4'h0, 32'h85);
    ret_begin(28'hFFFFFF1, 6'h10, 4'h4);
    rerr;
    cyc(14);
    chk("nochain_hf", 32'({s_hf, s_take, s_end}), 32'h5);
    wr(4'h0, 32'h87);
  endtask

  task automatic t_rerr;
    ret_begin(28'hFFFFFF1, 6'h10, 4'h4);
    rerr;
    {late_valid_in, late_exc_in} <= {1'b1, 6'h02, 4'hE};
    tc_go;
    late_valid_in <= 1'b0;
    chk("rerr_chain", 32'(s_skip), 32'h1);
    chk("rerr_pend", 32'(c_pend), 32'h3);
    chk("rerr_take", 32'(c_take), 32'h2);
    ret_begin(28'hFFFFFF1, 6'h03, 4'hF);
    rerr;
    cyc(3);
    chk("rerr_lock", 32'(lockup_out), 32'h1);
    do_rst;
  endtask

  initial
  begin
    cyc(16);
    rst_in <= 1'b0;
    t_regs;
    t_late;
    t_lmul;
    t_derv;
    t_tail;
    t_dest;
    t_ctrl;
    t_rerr;
    conclude;
  end

  // Whole run needs well under two thousand cycles
  initial
  begin
    cyc(20000);
    bad_count++;
    conclude;
  end
endmodule
`default_nettype wire
